//--- branch_bit_exec.sv
/*
 * Decode and execute for the clear-flag short branches, the unconditional
 * relative branch and the set-file-bit instruction.
 * Assumes the fetch unit presents one instruction word with its address at
 * the decode phase, and a data memory that answers a read within one phase.
 */

`timescale 1ns/100ps

module branch_bit_exec
    import branch_exec_pkg::*;
(
    input  wire logic                              ref_clk,      // core clock
    input  wire logic                              sys_rst,      // async reset
    input  wire logic                              clk_en,       // freezes all
    input  wire logic                              instr_valid,  // word ready
    input  wire logic [15:0]                       instr_word,   // opcode
    input  wire logic [branch_exec_pkg::PC_W-1:0]  instr_pc,     // its address
    input  wire branch_exec_pkg::flags_t           status_flags, // live flags
    input  wire logic [3:0]                        bank_select_register, // bank
    input  wire logic                              ext_set_en,   // extended set
    input  wire logic [branch_exec_pkg::ADDR_W-1:0] index_base,  // literal base
    input  wire logic [7:0]                        file_rdata,   // read data
    output branch_exec_pkg::file_req_t             file_req,     // data access
    output logic                                   pc_load,      // pc write
    output logic [branch_exec_pkg::PC_W-1:0]       pc_target,    // new pc
    output logic [1:0]                             phase,        // q phase
    output logic                                   flush_cycle,  // nop cycle
    output logic                                   flags_we      // always low
);
    import branch_exec_pkg::*;

    // ------------------------------------------------------------------
    // phase counter
    // ------------------------------------------------------------------
    logic [1:0] phase_q, phase_d;

    always_comb begin
        phase_d = phase_q + 2'h1;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= PHASE_DECODE;
        end else if (clk_en) begin
            phase_q <= phase_d;
        end
    end

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    op_t dec_op;

    always_comb begin
        dec_op = OP_NONE;
        case (instr_word[15:8])
            OPC_BRANCH_CARRY_CLEAR:    dec_op = OP_CARRY_CLR;
            OPC_BRANCH_NEGATIVE_CLEAR: dec_op = OP_NEG_CLR;
            OPC_BRANCH_OVERFLOW_CLEAR: dec_op = OP_OVF_CLR;
            OPC_BRANCH_ZERO_CLEAR:     dec_op = OP_ZERO_CLR;
            default: begin
                if (instr_word[15:11] == OPC_BRANCH_ALWAYS) begin
                    dec_op = OP_ALWAYS;
                end else if (instr_word[15:12] == OPC_SET_FILE_BIT) begin
                    dec_op = OP_SET_BIT;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // execute state
    // ------------------------------------------------------------------
    op_t             op_q, op_d;
    logic [15:0]     word_q, word_d;
    logic [PC_W-1:0] pc_q, pc_d;
    flags_t          flg_q, flg_d;
    logic            taken_q, taken_d;
    logic            flush_q, flush_d;
    logic [7:0]      data_q, data_d;
    file_req_t       req_q, req_d;
    logic            load_q, load_d;
    logic [PC_W-1:0] tgt_q, tgt_d;
    logic [PC_W-1:0] adder_out;
    logic [ADDR_W-1:0] eff_addr;
    logic [7:0]      f_addr;

    branch_target_adder u_target (
        .instr_pc   (pc_q),
        .offset     (word_q[10:0]),
        .short_form (op_q != OP_ALWAYS),
        .target     (adder_out)
    );

    // the operand address settles from the live bank and index inputs at the
    // read phase edge; they must hold steady from decode up to that edge
    always_comb begin
        f_addr = word_q[7:0];
        if (!word_q[BANK_SEL_BIT] && ext_set_en && f_addr <= INDEXED_LIMIT) begin
            eff_addr = index_base + {4'h0, f_addr};
        end else if (!word_q[BANK_SEL_BIT]) begin
            // access bank: low part of bank 0, upper part is the sfr bank
            eff_addr = (f_addr <= ACCESS_LOW_LIMIT) ? {4'h0, f_addr}
                                                    : {ACCESS_HIGH_BANK, f_addr};
        end else begin
            eff_addr = {bank_select_register, f_addr};
        end
    end

    always_comb begin
        op_d    = op_q;
        word_d  = word_q;
        pc_d    = pc_q;
        flg_d   = flg_q;
        taken_d = taken_q;
        flush_d = flush_q;
        data_d  = data_q;
        req_d   = '0;
        req_d.addr = req_q.addr;
        load_d  = 1'b0;
        tgt_d   = tgt_q;
        case (phase_q)
            PHASE_DECODE: begin
                // a taken branch's second cycle executes nothing
                flush_d = taken_q;
                taken_d = 1'b0;
                // an offer in the nop cycle is dropped, not queued: the fetch
                // side must present the word at the branch target again
                if (!taken_q && instr_valid) begin
                    op_d   = dec_op;
                    word_d = instr_word;
                    pc_d   = instr_pc;
                    flg_d  = status_flags;
                end else begin
                    op_d = OP_NONE;
                end
            end
            PHASE_READ: begin
                if (op_q == OP_SET_BIT) begin
                    req_d.rd   = 1'b1;
                    req_d.addr = eff_addr;
                end
            end
            PHASE_PROCESS: begin
                data_d = file_rdata | (8'h01 << word_q[BIT_IDX_LSB +: 3]);
                case (op_q)
                    OP_CARRY_CLR: taken_d = !flg_q.carry;
                    OP_NEG_CLR:   taken_d = !flg_q.negative;
                    OP_OVF_CLR:   taken_d = !flg_q.overflow;
                    OP_ZERO_CLR:  taken_d = !flg_q.zero;
                    OP_ALWAYS:    taken_d = 1'b1;
                    default:      taken_d = 1'b0;
                endcase
                tgt_d = adder_out;
            end
            PHASE_WRITE: begin
                load_d = taken_q;
                if (op_q == OP_SET_BIT) begin
                    req_d.wr    = 1'b1;
                    req_d.wdata = data_q;
                end
            end
            default: begin
                op_d = OP_NONE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            op_q    <= OP_NONE;
            word_q  <= 16'h0000;
            pc_q    <= '0;
            flg_q   <= '0;
            taken_q <= 1'b0;
            flush_q <= 1'b0;
            data_q  <= 8'h00;
            req_q   <= '0;
            load_q  <= 1'b0;
            tgt_q   <= '0;
        end else if (clk_en) begin
            op_q    <= op_d;
            word_q  <= word_d;
            pc_q    <= pc_d;
            flg_q   <= flg_d;
            taken_q <= taken_d;
            flush_q <= flush_d;
            data_q  <= data_d;
            req_q   <= req_d;
            load_q  <= load_d;
            tgt_q   <= tgt_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // plain copies of registers, so every output but the tied-low flags_we leaves a flip-flop
    always_comb begin
        file_req    = req_q;
        pc_load     = load_q;
        pc_target   = tgt_q;
        phase       = phase_q;
        flush_cycle = flush_q;
        flags_we    = 1'b0;
    end

endmodule : branch_bit_exec

//--- branch_bit_exec_monitor.sv
/* port assertions for branch_bit_exec; bound to every instance below.
   assumes clk_en stays high across the cycles a property counts. */
`timescale 1ns/100ps
module branch_bit_exec_check
    import branch_exec_pkg::*;
(
    input wire logic                               ref_clk,     // clock
    input wire logic                               sys_rst,     // reset
    input wire logic                               clk_en,      // advance
    input wire logic                               instr_valid, // word ok
    input wire logic [15:0]                        instr_word,  // opcode
    input wire logic [branch_exec_pkg::PC_W-1:0]   instr_pc,    // address
    input wire branch_exec_pkg::flags_t            status_flags, // flags
    input wire logic [3:0]                   bank_select_register, // bank
    input wire branch_exec_pkg::file_req_t         file_req,    // access
    input wire logic                               pc_load,     // pc write
    input wire logic [branch_exec_pkg::PC_W-1:0]   pc_target,   // new pc
    input wire logic [1:0]                         phase,       // phase
    input wire logic                               flush_cycle, // nop
    input wire logic                               flags_we     // flags
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    logic            acc;
    logic            cond;
    logic            held;
    logic [7:0]      f_adr;
    logic [PC_W-1:0] off8;
    logic [PC_W-1:0] off11;
    // a decode edge that shows a pc write is the refused nop-cycle edge
    assign acc   = instr_valid && clk_en && phase == PHASE_DECODE
                   && !pc_load;
    assign cond  = instr_word[15:13] == 3'h7 && instr_word[12:11] == 2'h0
                   && instr_word[8];
    assign held  = (instr_word[15:8] == 8'he3 && status_flags.carry)
                 || (instr_word[15:8] == 8'he7 && status_flags.negative)
                 || (instr_word[15:8] == 8'he5 && status_flags.overflow)
                 || (instr_word[15:8] == 8'he1 && status_flags.zero);
    assign f_adr = instr_word[7:0];
    assign off8  = {{12{instr_word[7]}}, instr_word[7:0], 1'b0};
    assign off11 = {{9{instr_word[10]}}, instr_word[10:0], 1'b0};

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    flags_quiet_a: assert property (!flags_we)
        else $error("flag write seen");
    phase_step_a: assert property (clk_en |=> phase == $past(phase) + 2'h1)
        else $error("phase did not advance");
    read_slot_a: assert property (file_req.rd |-> phase == PHASE_PROCESS)
        else $error("read outside process phase");
    load_slot_a: assert property (pc_load |-> phase == PHASE_DECODE && !flush_cycle)
        else $error("pc load out of place");
    bank_read_a: assert property (acc && instr_word[15:12] == 4'h8 && instr_word[8] ##1 clk_en |=> file_req.rd && file_req.addr == {$past(bank_select_register), $past(f_adr, 2)})
        else $error("banked read wrong");
    write_back_a: assert property (file_req.rd && clk_en ##1 clk_en |=> file_req.wr && $stable(file_req.addr))
        else $error("write back missing");
    always_jump_a: assert property (acc && instr_word[15:11] == 5'h1a ##1 clk_en [*3] |=> pc_load && pc_target == $past(instr_pc, 4) + PC_STEP + $past(off11, 4))
        else $error("unconditional target wrong");
    cond_jump_a: assert property (acc && cond && !held ##1 clk_en [*3] |=> pc_load && pc_target == $past(instr_pc, 4) + PC_STEP + $past(off8, 4))
        else $error("conditional target wrong");
    cond_skip_a: assert property (acc && held ##1 clk_en [*3] |=> !pc_load)
        else $error("blocked branch taken");
    flush_follow_a: assert property (pc_load && clk_en |=> flush_cycle && !pc_load)
        else $error("nop cycle missing");
endmodule : branch_bit_exec_check

bind branch_bit_exec branch_bit_exec_check branch_bit_exec_check_i (
    .ref_clk, .sys_rst, .clk_en, .instr_valid, .instr_word, .instr_pc,
    .status_flags, .bank_select_register, .file_req, .pc_load, .pc_target,
    .phase, .flush_cycle, .flags_we);

//--- branch_bit_exec_test.sv
/* self-checking bench for branch_bit_exec: corner and random instructions
   driven at the falling edge; assumes the bound checker runs alongside. */
`timescale 1ns/100ps
module branch_bit_exec_test;
    import branch_exec_pkg::*;
    // ------------------------------------------------------------------
    // stimulus and checks
    // ------------------------------------------------------------------
    logic              ref_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              clk_en = 1'b1;
    logic              instr_valid = 1'b0;
    logic [15:0]       instr_word = 16'h0000;
    logic [PC_W-1:0]   instr_pc = '0;
    flags_t            status_flags = '0;
    logic [3:0]        bank_select_register = 4'h0;
    logic              ext_set_en = 1'b0;
    logic [ADDR_W-1:0] index_base = '0;
    logic [7:0]        file_rdata = 8'h00;
    file_req_t         file_req;
    logic              pc_load, flush_cycle, flags_we;
    logic [PC_W-1:0]   pc_target;
    logic [1:0]        phase;
    int                mismatches = 0;
    int                samples_checked = 0;
    logic [31:0]       seed = 32'h000133f7;

    always #12.5 ref_clk = ~ref_clk;

    branch_bit_exec branch_bit_exec_i (.ref_clk, .sys_rst, .clk_en,
        .instr_valid, .instr_word, .instr_pc, .status_flags,
        .bank_select_register, .ext_set_en, .index_base, .file_rdata,
        .file_req, .pc_load, .pc_target, .phase, .flush_cycle, .flags_we);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction : lfsr

    function automatic logic taken(input logic [15:0] w, input flags_t f);
        case (w[15:8])
            8'he3: return !f.carry;
            8'he7: return !f.negative;
            8'he5: return !f.overflow;
            8'he1: return !f.zero;
            default: return w[15:11] == 5'h1a;
        endcase
    endfunction : taken

    function automatic logic [PC_W-1:0] target(input logic [15:0] w,
                                               input logic [PC_W-1:0] pc);
        logic [PC_W-1:0] n;
        n = w[15:11] == 5'h1a ? {{10{w[10]}}, w[10:0]} : {{13{w[7]}}, w[7:0]};
        return pc + 21'h000002 + (n << 1);
    endfunction : target

    function automatic logic [ADDR_W-1:0] faddr(input logic [15:0] w);
        if (w[8])
            return {bank_select_register, w[7:0]};
        if (w[7:0] <= 8'h5f)
            return ext_set_en ? index_base + {4'h0, w[7:0]} : {4'h0, w[7:0]};
        return {4'hf, w[7:0]};
    endfunction : faddr

    function automatic logic [15:0] pick(input logic [31:0] s);
        case (s[18:16])
            3'h0: return {8'he3, s[7:0]};
            3'h1: return {8'he7, s[7:0]};
            3'h2: return {8'he5, s[7:0]};
            3'h3: return {8'he1, s[7:0]};
            3'h4: return {5'h1a, s[10:0]};
            3'h7: return {8'hff, s[7:0]};
            default: return {4'h8, s[11:0]};
        endcase
    endfunction : pick

    task automatic chk_bit(input string what, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", what, e, g);
        end
    endtask : chk_bit

    task automatic chk_vec(input string what, input logic [PC_W-1:0] e,
                           input logic [PC_W-1:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk_vec

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // one instruction from decode to write; flags flip after decode
    task automatic run(input logic [15:0] w, input flags_t fl);
        int k;
        logic [7:0] rd;
        logic go, setb;
        for (k = 0; phase !== 2'h0; k++) begin
            if (k > 8) begin
                mismatches++;
                report_and_stop();
            end
            @(negedge ref_clk);
        end
        seed = lfsr(seed);
        {index_base, bank_select_register, ext_set_en, rd} = seed[24:0];
        instr_pc = seed[31:11];
        go = taken(w, fl);
        setb = w[15:12] == 4'h8;
        instr_word = w;
        status_flags = fl;
        instr_valid = 1'b1;
        @(negedge ref_clk);
        instr_valid = 1'b0;
        status_flags = ~fl;
        if (seed[3]) begin
            clk_en = 1'b0;
            @(negedge ref_clk);
            chk_vec("frozen phase", 21'h000001, PC_W'(phase));
            clk_en = 1'b1;
        end
        @(negedge ref_clk);
        chk_bit("read strobe", setb, file_req.rd);
        if (setb)
            chk_vec("address", PC_W'(faddr(w)), PC_W'(file_req.addr));
        file_rdata = rd;
        @(negedge ref_clk);
        file_rdata = ~rd;
        chk_bit("early load", 1'b0, pc_load);
        @(negedge ref_clk);
        chk_bit("write strobe", setb, file_req.wr);
        if (setb)
            chk_vec("wdata", PC_W'(rd | (8'h01 << w[11:9])), PC_W'(file_req.wdata));
        chk_bit("pc load", go, pc_load);
        chk_bit("early nop", 1'b0, flush_cycle);
        chk_bit("flag write", 1'b0, flags_we);
        if (go) begin
            chk_vec("target", target(w, instr_pc), pc_target);
            instr_word = 16'h8f00;
            instr_valid = 1'b1;
            for (k = 0; k < 4; k++) begin
                @(negedge ref_clk);
                instr_valid = 1'b0;
                chk_bit("refused read", 1'b0, file_req.rd);
                chk_bit("nop cycle", 1'b1, flush_cycle);
            end
            @(negedge ref_clk);
            chk_bit("nop end", 1'b0, flush_cycle);
        end
    endtask : run

    initial begin
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk_vec("reset phase", 21'h000000, PC_W'(phase));
        chk_bit("reset load", 1'b0, pc_load);
        run(16'he380, 4'h0);
        run(16'he37f, 4'h1);
        run(16'hd400, 4'hf);
        run(16'hd3ff, 4'h0);
        run(16'h8e5f, 4'h0);
        run(16'h8060, 4'h0);
        run(16'hff00, 4'h0);
        repeat (300) begin
            seed = lfsr(seed);
            run(pick(seed), seed[23:20]);
        end
        report_and_stop();
    end
endmodule : branch_bit_exec_test

//--- branch_exec_pkg.sv
/*
 * Shared constants and types for the branch and bit-set execute block,
 * plus the small branch target adder that the execute block instantiates.
 * Assumes a 21-bit byte program counter and a 12-bit data address space.
 */

package branch_exec_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int PC_W   = 21;
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------------
    // opcode fields
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_BRANCH_CARRY_CLEAR    = 8'he3; // 1110 0011
    localparam logic [7:0] OPC_BRANCH_NEGATIVE_CLEAR = 8'he7; // 1110 0111
    localparam logic [7:0] OPC_BRANCH_OVERFLOW_CLEAR = 8'he5; // 1110 0101
    localparam logic [7:0] OPC_BRANCH_ZERO_CLEAR     = 8'he1; // 1110 0001
    localparam logic [4:0] OPC_BRANCH_ALWAYS         = 5'h1a; // 1101 0
    localparam logic [3:0] OPC_SET_FILE_BIT          = 4'h8;  // 1000
    localparam int         BIT_IDX_LSB  = 9;
    localparam int         BANK_SEL_BIT = 8;

    // ------------------------------------------------------------------
    // addressing and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] INDEXED_LIMIT    = 8'h5f;  // f <= 95
    localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5f;  // low access part
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;   // sfr part of access
    localparam logic [1:0] PHASE_DECODE     = 2'h0;
    localparam logic [1:0] PHASE_READ       = 2'h1;
    localparam logic [1:0] PHASE_PROCESS    = 2'h2;
    localparam logic [1:0] PHASE_WRITE      = 2'h3;
    localparam logic [PC_W-1:0] PC_STEP     = 21'h000002;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE, OP_CARRY_CLR, OP_NEG_CLR, OP_OVF_CLR, OP_ZERO_CLR,
        OP_ALWAYS, OP_SET_BIT
    } op_t;

    typedef struct packed {
        logic negative;
        logic overflow;
        logic zero;
        logic carry;
    } flags_t;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } file_req_t;

endpackage : branch_exec_pkg

`timescale 1ns/100ps

module branch_target_adder
    import branch_exec_pkg::*;
(
    input  wire logic [PC_W-1:0] instr_pc,   // address of the branch
    input  wire logic [10:0]     offset,     // signed word offset
    input  wire logic            short_form, // 8-bit offset in use
    output logic      [PC_W-1:0] target      // pc + 2 + 2n
);
    logic [PC_W-1:0] ext;

    always_comb begin
        // the fetch has already moved the pc one word on
        if (short_form) begin
            ext = {{(PC_W-9){offset[7]}}, offset[7:0], 1'b0};
        end else begin
            ext = {{(PC_W-12){offset[10]}}, offset, 1'b0};
        end
        target = instr_pc + PC_STEP + ext;
    end
endmodule : branch_target_adder
